// ==== fpg_pkg.sv ====
// Constants shared by the flash program guard and its serial link.
package fpg_pkg;
   // Protection identifier held in flash.
   localparam int          ID_BYTES       = 16;
   localparam logic [31:0] ID_ADDR_FIRST  = 32'h0000_0084;
   localparam logic [31:0] ID_ADDR_LAST   = 32'h0000_0093;
   localparam logic [7:0]  ID_BLANK_BYTE  = 8'hFF;
   // Flash status register layout and reset value.
   localparam logic [7:0]  STAT_RESET     = 8'h80;
   localparam int          STAT_READY     = 7;
   localparam int          STAT_ERASE_ERR = 5;
   localparam int          STAT_PROG_ERR  = 4;
   // Flash mode register layout.
   localparam logic [7:0]  MODE_RESET     = 8'h00;
   localparam int          MODE_GUARD     = 0;
   localparam int          MODE_ENTRY     = 1;
   // Serial link framing, strap settling, operation length and guard states.
   localparam int          SER_BITS       = 8;
   localparam logic [1:0]  STRAP_WAIT     = 2'h3;
   localparam int          PE_CYCLES_DEF  = 64;
   typedef enum logic [1:0] {
      FPG_IDLE = 2'b01,
      FPG_BUSY = 2'b10
   } fpg_state_t;
endpackage : fpg_pkg

// ==== fpg_ser_if.sv ====
// Byte-level connection between the guard core and its serial link.
`timescale 1ns/1ps
interface fpg_ser_if;
   logic [7:0] rx_data;
   logic       rx_valid;
   logic [7:0] tx_data;
   logic       tx_load;
   modport link (output rx_data, output rx_valid,
                 input tx_data, input tx_load);
   modport core (input rx_data, input rx_valid,
                 output tx_data, output tx_load);
endinterface : fpg_ser_if

// ==== fpg_serial.sv ====
// Clock-synchronous serial shifter sampled on the system clock.
`timescale 1ns/1ps
module fpg_serial
   import fpg_pkg::*;
(
   // System.
   input  wire logic clk,
   input  wire logic srst,
   // Link pins.
   input  wire logic sclk_in,
   input  wire logic rx_in,
   output logic      tx_out,
   // Byte side.
   fpg_ser_if.link   ser
);
   logic [2:0] sclk_sync_q;
   logic [1:0] rx_sync_q;
   logic [7:0] rx_sh_q;
   logic [7:0] tx_sh_q;
   logic [2:0] cnt_q;
   logic       rise;
   logic       fall;

   // Only the second and third stages feed the edge detector.
   assign rise = sclk_sync_q[1] & ~sclk_sync_q[2];
   assign fall = ~sclk_sync_q[1] & sclk_sync_q[2];

   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_sync_q <= 3'h7;
         rx_sync_q   <= 2'h3;
      end else begin
         sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
         rx_sync_q   <= {rx_sync_q[0], rx_in};
      end
   end

   // Receive data is taken on the rising transfer clock edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_sh_q      <= 8'h00;
         cnt_q        <= 3'h0;
         ser.rx_valid <= 1'b0;
         ser.rx_data  <= 8'h00;
      end else begin
         ser.rx_valid <= 1'b0;
         if (rise) begin
            rx_sh_q <= {rx_sync_q[1], rx_sh_q[7:1]};
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'(SER_BITS - 1)) begin
               ser.rx_valid <= 1'b1;
               ser.rx_data  <= {rx_sync_q[1], rx_sh_q[7:1]};
            end
         end
      end
   end

   // Transmit data changes on the falling edge, ahead of the next rise.
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_sh_q <= 8'hFF;
         tx_out  <= 1'b1;
      end else if (ser.tx_load) begin
         tx_sh_q <= ser.tx_data;
      end else if (fall) begin
         tx_out  <= tx_sh_q[0];
         tx_sh_q <= {1'b1, tx_sh_q[7:1]};
      end
   end

   a_rx_byte_done: assert property (@(posedge clk) disable iff (srst)
      ser.rx_valid |-> $past(rise) && $past(cnt_q) == 3'h7)
      else $error("byte completed without its eighth rising edge");
endmodule : fpg_serial

// ==== fpg_guard.sv ====
// Flash program and erase guard with serial programmer link.
// Behaviour
// - Program or erase refused unless the tool identifier equals the stored one.
// - The stored identifier is the sixteen bytes from 0x84 to 0x93.
// - Write-guard pin low blocks every program and erase in hardware, except under JTAG programming.
// - Mode register shows the current write-guard pin level.
// - Program/erase mode needs the mode-entry bit set.
// - Entry bit sets only after writes of 0 then 1, guard pin high.
// - A block whose lock bit is 0 refuses program and erase.
// - Error clear returns status to 0x80; used only while ready.
// - Under JTAG programming the guard pin level is ignored.
// - Boot link is clocked serial; device returns data and transfer enable.
`timescale 1ns/1ps
module fpg_guard
   import fpg_pkg::*;
#(
   parameter int NUM_BLOCKS = 8,
   parameter int BLK_W      = 3,
   parameter int PE_CYCLES  = PE_CYCLES_DEF
) (
   // System.
   input  wire logic                  clk,
   input  wire logic                  srst,
   // Pins.
   input  wire logic                  flash_write_guard_pin,
   input  wire logic                  op_select_pin_a,
   input  wire logic                  op_select_pin_b,
   input  wire logic                  op_select_pin_c,
   input  wire logic                  system_break_irq_n,
   input  wire logic                  serial_xfer_clock_in,
   input  wire logic                  serial_rx_in,
   output logic                       serial_tx_out,
   output logic                       xfer_enable_out,
   // Identifier check.
   input  wire logic [ID_BYTES*8-1:0] stored_id,
   input  wire logic [ID_BYTES*8-1:0] tool_id_in,
   input  wire logic                  tool_id_load,
   input  wire logic                  jtag_program_mode,
   // Control writes.
   input  wire logic                  ctl_one_wr,
   input  wire logic                  ctl_one_entry_wdata,
   input  wire logic                  error_status_clear_bit,
   // Program and erase requests.
   input  wire logic                  pe_req,
   input  wire logic                  pe_erase,
   input  wire logic [BLK_W-1:0]      pe_block,
   input  wire logic [NUM_BLOCKS-1:0] block_lock_bits,
   output logic                       pe_grant,
   output logic                       pe_reject,
   // Status.
   output logic [7:0]                 flash_mode_reg,
   output logic [7:0]                 flash_status_reg,
   output logic                       program_mode_entry_bit,
   output logic                       guard_pin_level_bit,
   output logic                       flash_ready_flag,
   output logic                       boot_mode,
   output logic                       id_match
);
   fpg_ser_if ser ();

   logic [1:0]              guard_sync_q;
   logic [2:0]              mode_sync_q [2];
   logic [1:0]              strap_cnt_q;
   logic                    armed_q;
   logic [ID_BYTES*8-1:0]   tool_id_q;
   logic [$clog2(PE_CYCLES+1)-1:0] busy_cnt_q;
   fpg_state_t              state_q;
   logic                    guard_ok;
   logic                    allowed;
   logic                    unused_brk;

   fpg_serial u_serial (
      .clk     (clk),
      .srst    (srst),
      .sclk_in (serial_xfer_clock_in),
      .rx_in   (serial_rx_in),
      .tx_out  (serial_tx_out),
      .ser     (ser.link)
   );

   // The break input is strapped by the board and plays no part here.
   assign unused_brk = system_break_irq_n;

   always_ff @(posedge clk) begin
      if (srst) begin
         guard_sync_q   <= 2'h0;
         mode_sync_q[0] <= 3'h0;
         mode_sync_q[1] <= 3'h0;
      end else begin
         guard_sync_q   <= {guard_sync_q[0], flash_write_guard_pin};
         mode_sync_q[0] <= {op_select_pin_c, op_select_pin_b,
                            op_select_pin_a};
         mode_sync_q[1] <= mode_sync_q[0];
      end
   end

   // Mode pins are caught once, after the synchronisers have filled.
   always_ff @(posedge clk) begin
      if (srst) begin
         strap_cnt_q <= 2'h0;
         boot_mode   <= 1'b0;
      end else if (strap_cnt_q != STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == STRAP_WAIT - 2'h1) begin
            boot_mode <= (mode_sync_q[1] == 3'b001);
         end
      end
   end

   assign guard_pin_level_bit = guard_sync_q[1];
   assign guard_ok = guard_sync_q[1] | jtag_program_mode;

   // A zero write arms; only the very next write of one sets the bit.
   always_ff @(posedge clk) begin
      if (srst) begin
         armed_q                <= 1'b0;
         program_mode_entry_bit <= 1'b0;
      end else if (ctl_one_wr) begin
         armed_q <= ~ctl_one_entry_wdata & guard_ok;
         if (!ctl_one_entry_wdata) begin
            program_mode_entry_bit <= 1'b0;
         end else if (armed_q && guard_ok) begin
            program_mode_entry_bit <= 1'b1;
         end
      end
   end

   // Tool identifier arrives in parallel, or byte by byte in boot mode.
   always_ff @(posedge clk) begin
      if (srst) begin
         tool_id_q <= '0;
      end else if (tool_id_load) begin
         tool_id_q <= tool_id_in;
      end else if (boot_mode && ser.rx_valid) begin
         tool_id_q <= {ser.rx_data, tool_id_q[ID_BYTES*8-1:8]};
      end
   end

   // A blank 0xFF identifier still needs a matching tool identifier.
   always_ff @(posedge clk) begin
      if (srst) begin
         id_match <= 1'b0;
      end else begin
         id_match <= (tool_id_q == stored_id);
      end
   end

   assign flash_ready_flag = (state_q == FPG_IDLE);
   assign allowed = program_mode_entry_bit & guard_ok & id_match
                  & block_lock_bits[pe_block] & flash_ready_flag;

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q    <= FPG_IDLE;
         busy_cnt_q <= '0;
         pe_grant   <= 1'b0;
      end else begin
         pe_grant <= 1'b0;
         unique case (state_q)
            FPG_IDLE: begin
               if (pe_req && allowed) begin
                  state_q    <= FPG_BUSY;
                  busy_cnt_q <= ($clog2(PE_CYCLES+1))'(PE_CYCLES - 1);
                  pe_grant   <= 1'b1;
               end
            end
            FPG_BUSY: begin
               if (busy_cnt_q == '0) begin
                  state_q <= FPG_IDLE;
               end else begin
                  busy_cnt_q <= busy_cnt_q - 1'b1;
               end
            end
         endcase
      end
   end

   // A refusal in the clear cycle still sets its error bit.
   always_ff @(posedge clk) begin
      if (srst) begin
         flash_status_reg <= STAT_RESET;
         pe_reject        <= 1'b0;
      end else begin
         pe_reject <= pe_req & ~allowed;
         flash_status_reg[STAT_READY] <= flash_ready_flag;
         if (error_status_clear_bit) begin
            flash_status_reg[6:0] <= STAT_RESET[6:0];
         end
         if (pe_req && !allowed) begin
            flash_status_reg[STAT_ERASE_ERR] <= pe_erase;
            flash_status_reg[STAT_PROG_ERR]  <= ~pe_erase;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flash_mode_reg <= MODE_RESET;
      end else begin
         flash_mode_reg             <= MODE_RESET;
         flash_mode_reg[MODE_GUARD] <= guard_sync_q[1];
         flash_mode_reg[MODE_ENTRY] <= program_mode_entry_bit;
      end
   end

   // Each answer byte after the first (0xFF) carries the status; enable low means ready.
   always_ff @(posedge clk) begin
      if (srst) begin
         ser.tx_load     <= 1'b0;
         ser.tx_data     <= 8'hFF;
         xfer_enable_out <= 1'b1;
      end else begin
         ser.tx_load     <= boot_mode & ser.rx_valid;
         ser.tx_data     <= flash_status_reg;
         xfer_enable_out <= ~(boot_mode & flash_ready_flag);
      end
   end

   // Counts the busy cycles of one operation, so that its length can be
   // checked without a long repetition in the property.
   logic [$clog2(PE_CYCLES+1)-1:0] busy_len_q;

   always_ff @(posedge clk) begin
      if (srst || flash_ready_flag) begin
         busy_len_q <= '0;
      end else begin
         busy_len_q <= busy_len_q + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_grant_needs_id: assert property (pe_grant |-> $past(id_match))
      else $error("grant without identifier match");
   a_guard_blocks: assert property (
      pe_req && !guard_sync_q[1] && !jtag_program_mode |=> !pe_grant)
      else $error("grant while guard pin low");
   a_guard_status: assert property (
      flash_mode_reg[MODE_GUARD] == $past(guard_pin_level_bit))
      else $error("mode register misses guard level");
   a_entry_needed: assert property (
      pe_grant |-> $past(program_mode_entry_bit))
      else $error("grant without entry bit");
   a_entry_sequence: assert property (
      $rose(program_mode_entry_bit) |-> $past(ctl_one_wr)
      && $past(ctl_one_entry_wdata) && $past(armed_q))
      else $error("entry bit set without 0 then 1");
   a_lock_blocks: assert property (
      pe_req && !block_lock_bits[pe_block] |=> pe_reject && !pe_grant)
      else $error("locked block not refused");
   a_error_clear: assert property (
      error_status_clear_bit && !pe_req |=> flash_status_reg[6:0] == 7'h00)
      else $error("error clear did not restore status");
   a_busy_length: assert property (
      $rose(flash_ready_flag) |->
      busy_len_q == ($clog2(PE_CYCLES+1))'(PE_CYCLES))
      else $error("busy length differs from the operation time");
   a_jtag_override: assert property (
      pe_req && allowed && jtag_program_mode |=> pe_grant)
      else $error("jtag programming blocked");

   c_grant: cover property (pe_grant);
   c_reject_locked: cover property (pe_reject && !block_lock_bits[pe_block]);
   c_boot_byte: cover property (boot_mode && ser.rx_valid);
   c_entry_set: cover property ($rose(program_mode_entry_bit));
endmodule : fpg_guard

// ==== fpg_prog_model.sv ====
// Behavioural clocked serial programmer on the far side of the boot link.
`timescale 1ns/1ps
module fpg_prog_model (
   // Link pins.
   output logic      sclk,
   output logic      rx,
   input  wire logic tx
);
   // Both lines rest high on their pull-ups; the clock stays still between
   // bytes, so the device must not rely on a free-running link clock.
   initial begin
      sclk = 1'b1;
      rx   = 1'b1;
   end

   // One byte each way, data LSB first, taken by both sides on the rise.
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 0; i < 8; i++) begin
         sclk = 1'b0;
         rx   = d[i];
         #62.5;
         sclk = 1'b1;
         q[i] = tx;
         #62.5;
      end
      rx = 1'b1;
   endtask : xfer
endmodule : fpg_prog_model

// ==== fpg_guard_tb.sv ====
// Self-checking bench for the flash program guard.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; \
   if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module fpg_guard_tb
   import fpg_pkg::*;
();
   typedef struct packed {
      logic       g;
      logic       j;
      logic       e;
      logic [2:0] b;
      logic [7:0] lk;
      logic       ok;
   } fpg_row_t;

   logic         clk, srst, guard, pin_a, jtag, wr, wdat, eclr, req, ers;
   logic         sclk, rx, tx, xen, grant, rej, entry, gbit, rdy, boot, idm;
   logic         tload;
   logic [2:0]   blk;
   logic [7:0]   locks, mode, stat, rb, es;
   logic [127:0] sid, tid;
   int           miscompares, comparisons;
   // Rows: guard pin, jtag, erase, block, lock bits, expected grant.
   fpg_row_t     rows [5] = '{
      '{1'b1, 1'b0, 1'b0, 3'h3, 8'hFF, 1'b1},
      '{1'b0, 1'b0, 1'b0, 3'h3, 8'hFF, 1'b0},
      '{1'b0, 1'b1, 1'b1, 3'h0, 8'hFF, 1'b1},
      '{1'b1, 1'b0, 1'b1, 3'h5, 8'hDF, 1'b0},
      '{1'b1, 1'b0, 1'b1, 3'h7, 8'hBF, 1'b1}
   };

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   fpg_guard #(.PE_CYCLES(4)) u_dut (
      .clk(clk), .srst(srst), .flash_write_guard_pin(guard),
      .op_select_pin_a(pin_a), .op_select_pin_b(1'b0),
      .op_select_pin_c(1'b0), .system_break_irq_n(1'b1),
      .serial_xfer_clock_in(sclk), .serial_rx_in(rx), .serial_tx_out(tx),
      .xfer_enable_out(xen), .stored_id(sid), .tool_id_in(tid),
      .tool_id_load(tload), .jtag_program_mode(jtag), .ctl_one_wr(wr),
      .ctl_one_entry_wdata(wdat), .error_status_clear_bit(eclr),
      .pe_req(req), .pe_erase(ers), .pe_block(blk),
      .block_lock_bits(locks), .pe_grant(grant), .pe_reject(rej),
      .flash_mode_reg(mode), .flash_status_reg(stat),
      .program_mode_entry_bit(entry), .guard_pin_level_bit(gbit),
      .flash_ready_flag(rdy), .boot_mode(boot), .id_match(idm));

   fpg_prog_model u_prog (.sclk(sclk), .rx(rx), .tx(tx));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic ctl(input logic d);
      wr   = 1'b1;
      wdat = d;
      cyc(1);
      wr   = 1'b0;
      cyc(1);
   endtask : ctl

   // Returns just after the taking edge, while the one-cycle answer stands.
   task automatic request(input logic e, input logic [2:0] b);
      req = 1'b1;
      ers = e;
      blk = b;
      cyc(1);
      req = 1'b0;
   endtask : request

   task automatic wait_ready();
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      `CHK("ready", 1'b1, rdy)
   endtask : wait_ready

   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      {srst, guard, pin_a} = 3'b111;
      {jtag, wr, wdat, eclr, req, ers, tload} = 7'h00;
      blk   = 3'h0;
      locks = 8'hFF;
      sid   = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
      tid   = sid;
      comparisons = 0;
      miscompares = 0;
      cyc(2);
      `CHK("reset status", STAT_RESET, stat)
      `CHK("reset enable", 1'b1, xen)
      srst = 1'b0;
      cyc(4);
      `CHK("boot mode", 1'b1, boot)
      `CHK("xfer enable", 1'b0, xen)
      $display("test reset done");
      for (int k = 0; k < ID_BYTES; k++) begin
         u_prog.xfer(sid[k*8 +: 8], rb);
         if (k > 0) `CHK("tx byte", STAT_RESET, rb)
         else `CHK("tx first", 8'hFF, rb)
      end
      cyc(8);
      `CHK("id match", 1'b1, idm)
      $display("test serial done");
      ctl(1'b0);
      ctl(1'b1);
      `CHK("entry set", 1'b1, mode[MODE_ENTRY])
      foreach (rows[i]) begin
         guard = rows[i].g;
         jtag  = rows[i].j;
         locks = rows[i].lk;
         cyc(4);
         `CHK("guard bit", rows[i].g, gbit)
         `CHK("mode guard", rows[i].g, mode[MODE_GUARD])
         request(rows[i].e, rows[i].b);
         `CHK("grant", rows[i].ok, grant)
         `CHK("reject", ~rows[i].ok, rej)
         cyc(2);
         `CHK("busy enable", rows[i].ok, xen)
         wait_ready();
         cyc(1);
         es = 8'h01 << (rows[i].e ? STAT_ERASE_ERR : STAT_PROG_ERR);
         es = rows[i].ok ? STAT_RESET : (STAT_RESET | es);
         `CHK("status", es, stat)
         eclr = 1'b1;
         cyc(1);
         eclr = 1'b0;
         cyc(1);
         `CHK("cleared", STAT_RESET, stat)
      end
      jtag = 1'b0;
      $display("test table done");
      ctl(1'b0);
      `CHK("entry clear", 1'b0, entry)
      request(1'b0, 3'h1);
      `CHK("no entry", 1'b1, rej)
      guard = 1'b0;
      cyc(4);
      ctl(1'b1);
      `CHK("entry guarded", 1'b0, entry)
      guard = 1'b1;
      cyc(4);
      ctl(1'b1);
      `CHK("entry 1 then 1", 1'b0, entry)
      ctl(1'b0);
      ctl(1'b1);
      `CHK("entry again", 1'b1, entry)
      $display("test entry done");
      tid   = sid ^ 128'h1;
      tload = 1'b1;
      cyc(1);
      tload = 1'b0;
      cyc(2);
      `CHK("id differs", 1'b0, idm)
      request(1'b1, 3'h2);
      `CHK("id reject", 1'b1, rej)
      sid = {ID_BYTES{ID_BLANK_BYTE}};
      cyc(2);
      `CHK("blank id", 1'b0, idm)
      tid   = sid;
      tload = 1'b1;
      cyc(1);
      tload = 1'b0;
      cyc(2);
      `CHK("blank id match", 1'b1, idm)
      $display("test id done");
      tally_and_finish();
   end
endmodule : fpg_guard_tb
